// ==== rtl/srpm_defines.svh ====
`ifndef SRPM_DEFINES_SVH
`define SRPM_DEFINES_SVH

// Register byte offsets
`define SRPM_ADDR_PERIOD    8'h00
`define SRPM_ADDR_LOWPOWER  8'h04
`define SRPM_ADDR_TIMING    8'h08
`define SRPM_ADDR_STATUS    8'h0C

// Low-power settings fields
`define SRPM_LP_CMD_LSB     0
`define SRPM_LP_FREEZE_BIT  2
`define SRPM_LP_TMO_LSB     4
`define SRPM_LP_UPDSEL_BIT  6
`define SRPM_LP_EMR_LSB     8
`define SRPM_LP_EMR_MSB     14
`define SRPM_LP_MEM_LSB     16
`define SRPM_LP_WIDTH       18

// Timing fields, in controller cycles
`define SRPM_TM_TRAS_LSB    0
`define SRPM_TM_TRFC_LSB    8
`define SRPM_TM_TCKE_LSB    16
`define SRPM_TM_TXP_LSB     24

// Low-power command codes
`define SRPM_LPC_NONE       2'h0
`define SRPM_LPC_SELF       2'h1
`define SRPM_LPC_PDOWN      2'h2
`define SRPM_LPC_DEEP       2'h3

// Timeout codes and idle thresholds
`define SRPM_TMO_NOW        2'h0
`define SRPM_TMO_64         2'h1
`define SRPM_TMO_128        2'h2
`define SRPM_IDLE_64        8'h40
`define SRPM_IDLE_128       8'h80

// Reset values
`define SRPM_PERIOD_RST     21'h000000
`define SRPM_LP_RST         18'h00000
`define SRPM_TIMING_RST     32'h01010101

// Clock and refresh limit
`define SRPM_CLK_NS         40
`define SRPM_REFRESH_MAX_MS 64
`define SRPM_REFRESH_MAX_CYC \
	(`SRPM_REFRESH_MAX_MS * 1000000 / `SRPM_CLK_NS)

`endif

// ==== rtl/srpm_pkg.sv ====
package srpm_pkg;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_REF   = 4'h1,
		ST_PRE   = 4'h2,
		ST_SRCMD = 4'h3,
		ST_SR    = 4'h4,
		ST_WAKE  = 4'h5,
		ST_PD    = 4'h6,
		ST_EMR   = 4'h7,
		ST_DEEP  = 4'h8,
		ST_RST   = 4'h9
	} srpm_state_e;

	typedef enum logic [2:0] {
		CMD_NOP      = 3'h0,
		CMD_PREALL   = 3'h1,
		CMD_AUTOREF  = 3'h2,
		CMD_SELFREF  = 3'h3,
		CMD_LOADEMR  = 3'h4,
		CMD_PDENTER  = 3'h5,
		CMD_DEEPPD   = 3'h6,
		CMD_DDRRESET = 3'h7
	} srpm_cmd_e;

	typedef enum logic [1:0] {
		MEM_SDR    = 2'h0,
		MEM_LPSDR  = 2'h1,
		MEM_LPDDR1 = 2'h2,
		MEM_DDR2   = 2'h3
	} srpm_mem_e;

	typedef struct packed {
		srpm_state_e state;
		logic        ref_pend;
		logic        emr_dirty;
		logic [7:0]  idle_cnt;
		logic [20:0] period;
		logic [17:0] lp;
		logic [31:0] timing;
		logic        a_valid;
		logic        a_write;
		logic [7:0]  a_addr;
		logic [31:0] hrdata;
		logic        hready;
		logic        cke;
		srpm_cmd_e   cmd;
		logic        cmd_stb;
		logic        busy;
		logic        frozen;
		logic        normal;
	} srpm_regs_s;

	typedef struct packed {
		logic [20:0] count;
	} srpm_timer_s;

endpackage

// ==== rtl/srpm_timer.sv ====
`timescale 1ns/1ns
module srpm_timer #(
	parameter int W = 21
) (
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic      [W-1:0] count_o,
	output logic              zero_o
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb
	begin
		count_next = count_reg;
		if (load_i)
			count_next = value_i;
		else if (count_reg != '0)
			count_next = count_reg - W'(1);
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	assign count_o = count_reg;
	assign zero_o  = (count_reg == '0);
endmodule // srpm_timer

// ==== rtl/srpm_top.sv ====
// Summary of operation
// - Refresh timer loads programmed period and issues auto-refresh on expiry.
// - Masters accessing during refresh see busy until it completes.
// - Pending refresh waits for any running burst to finish.
// - Command 01 selects self-refresh; clock enable held low.
// - An access during self-refresh triggers exit sequence before service.
// - Timeout 00 enters at once, 01 after 64, 10 after 128 idle cycles.
// - Entry issues precharge-all then self-refresh, or auto-refresh if accessed.
// - Changed array, drive or temperature settings rewrite the extended mode.
// - Update select: before self-refresh, or during refresh with pending access.
// - Self-refresh held at least TRAS, TRFC or TCKE by memory type.
// - Command 10 selects power-down; clock enable low once unaccessed.
// - Refreshes continue in power-down; never stay past 64 ms period.
// - Power-down exit uses NOP; low-power DDR1 holds NOP for TXP.
// - Low-power DDR1 and DDR2 stay in power-down at least TCKE.
// - After accesses, power-down is re-entered honouring the timeout.
// - Command 11, freeze clear: deep power-down, leave normal mode, freeze.
// - Command 11 with freeze set: DDR2 reset mode, leave normal, freeze.
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`include "srpm_defines.svh"
module srpm_top #(
	parameter logic [20:0] REFRESH_MAX_CYC = 21'(`SRPM_REFRESH_MAX_CYC)
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic [31:0]      hrdata_o,
	output logic             hresp_o,
	input  wire logic        init_done_i,
	input  wire logic        access_req_i,
	input  wire logic        burst_active_i,
	output logic             busy_o,
	output logic             cke_o,
	output logic [2:0]       cmd_o,
	output logic             cmd_stb_o,
	output logic [6:0]       emr_o,
	output logic             normal_mode_o,
	output logic             frozen_o
);
	srpm_pkg::srpm_regs_s r;
	srpm_pkg::srpm_regs_s n;

	logic        ref_load;
	logic [20:0] ref_val;
	logic [20:0] period_src;
	logic [20:0] period_cap;
	logic [20:0] ref_count;
	logic        ref_zero;
	logic        ref_expire;
	logic        wait_load;
	logic [20:0] wait_val;
	logic        wait_zero;
	logic [1:0]  lpc;
	logic        freeze;
	logic [1:0]  tmo;
	logic        upd_sel;
	srpm_pkg::srpm_mem_e mem;
	logic [7:0]  t_ras;
	logic [7:0]  t_rfc;
	logic [7:0]  t_cke;
	logic [7:0]  t_xp;
	logic [7:0]  sr_min;
	logic [7:0]  pd_min;
	logic [7:0]  wake_len;
	logic        entry_ok;
	logic        bus_take;
	logic        wr_now;

	////////////////////////////////////////////////////////////////////
	// Field decode

	assign lpc     = r.lp[`SRPM_LP_CMD_LSB +: 2];
	assign freeze  = r.lp[`SRPM_LP_FREEZE_BIT];
	assign tmo     = r.lp[`SRPM_LP_TMO_LSB +: 2];
	assign upd_sel = r.lp[`SRPM_LP_UPDSEL_BIT];
	assign mem     = srpm_pkg::srpm_mem_e'(r.lp[`SRPM_LP_MEM_LSB +: 2]);
	assign t_ras   = r.timing[`SRPM_TM_TRAS_LSB +: 8];
	assign t_rfc   = r.timing[`SRPM_TM_TRFC_LSB +: 8];
	assign t_cke   = r.timing[`SRPM_TM_TCKE_LSB +: 8];
	assign t_xp    = r.timing[`SRPM_TM_TXP_LSB +: 8];

	always_comb
	begin
		case (mem)
			srpm_pkg::MEM_LPDDR1:
			begin
				sr_min   = t_rfc;
				pd_min   = t_cke;
				wake_len = t_xp;
			end
			srpm_pkg::MEM_DDR2:
			begin
				sr_min   = t_cke;
				pd_min   = t_cke;
				wake_len = 8'h01;
			end
			default:
			begin
				sr_min   = t_ras;
				pd_min   = 8'h01;
				wake_len = 8'h01;
			end
		endcase
	end

	// Idle threshold before re-entering a low-power state
	always_comb
	begin
		case (tmo)
			`SRPM_TMO_NOW: entry_ok = 1'b1;
			`SRPM_TMO_64:  entry_ok = (r.idle_cnt >= `SRPM_IDLE_64);
			`SRPM_TMO_128: entry_ok = (r.idle_cnt >= `SRPM_IDLE_128);
			default:       entry_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Timers

	// Capped so power-down never outlasts the array retention time
	// A period write starts its own interval at once, not the old one
	assign wr_now = r.a_valid && r.a_write;
	assign period_src = (wr_now && r.a_addr == `SRPM_ADDR_PERIOD)
		? hwdata_i[20:0] : r.period;
	assign period_cap = (period_src > REFRESH_MAX_CYC) ? REFRESH_MAX_CYC
		: period_src;
	assign ref_val = (period_cap == '0) ? '0
		: period_cap - 21'h000001;
	assign ref_expire = ref_zero && (r.period != '0);
	assign ref_load = ref_expire
		|| (wr_now && r.a_addr == `SRPM_ADDR_PERIOD);

	srpm_timer #(.W(21)) u_ref_timer (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.load_i  (ref_load),
		.value_i (ref_val),
		.count_o (ref_count),
		.zero_o  (ref_zero)
	);

	srpm_timer #(.W(21)) u_wait_timer (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.load_i  (wait_load),
		.value_i (wait_val),
		.count_o (),
		.zero_o  (wait_zero)
	);

	assign bus_take = hsel_i && hready_i && htrans_i[1];

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		n = r;
		n.cmd_stb = 1'b0;
		n.cmd = srpm_pkg::CMD_NOP;
		n.hready = 1'b1;
		wait_load = 1'b0;
		wait_val = '0;

		// Register bus: zero wait, reads prepared in address phase
		n.a_valid = bus_take;
		n.a_write = hwrite_i;
		n.a_addr = haddr_i[7:0];
		if (bus_take && !hwrite_i && haddr_i[31:8] == '0)
		begin
			case (haddr_i[7:0])
				`SRPM_ADDR_PERIOD:   n.hrdata = {11'h000, r.period};
				`SRPM_ADDR_LOWPOWER: n.hrdata = {14'h0000, r.lp};
				`SRPM_ADDR_TIMING:   n.hrdata = r.timing;
				`SRPM_ADDR_STATUS:   n.hrdata = {24'h000000, r.cke,
					r.emr_dirty, r.ref_pend, 1'b0, r.state};
				default:             n.hrdata = 32'h00000000;
			endcase
		end
		else if (bus_take)
			n.hrdata = 32'h00000000;
		if (wr_now)
		begin
			case (r.a_addr)
				`SRPM_ADDR_PERIOD:   n.period = hwdata_i[20:0];
				`SRPM_ADDR_LOWPOWER: n.lp = hwdata_i[17:0];
				`SRPM_ADDR_TIMING:   n.timing = hwdata_i;
				default:             n.lp = r.lp;
			endcase
		end

		// Idle count since the last access ended
		if (access_req_i || burst_active_i)
			n.idle_cnt = '0;
		else if (r.idle_cnt != 8'hFF)
			n.idle_cnt = r.idle_cnt + 8'h01;

		case (r.state)
			srpm_pkg::ST_IDLE:
			begin
				n.cke = 1'b1;
				if (burst_active_i)
					n.state = r.state;
				else if (lpc == `SRPM_LPC_DEEP)
				begin
					n.cke = 1'b0;
					n.cmd_stb = 1'b1;
					if (freeze)
					begin
						n.cmd = srpm_pkg::CMD_DDRRESET;
						n.state = srpm_pkg::ST_RST;
					end
					else
					begin
						n.cmd = srpm_pkg::CMD_DEEPPD;
						n.state = srpm_pkg::ST_DEEP;
					end
				end
				else if (r.ref_pend)
				begin
					n.cmd = srpm_pkg::CMD_AUTOREF;
					n.cmd_stb = 1'b1;
					n.ref_pend = 1'b0;
					wait_load = 1'b1;
					wait_val = {13'h0000, t_rfc};
					n.state = srpm_pkg::ST_REF;
				end
				else if (!access_req_i && entry_ok
					&& lpc == `SRPM_LPC_SELF)
				begin
					n.cmd = srpm_pkg::CMD_PREALL;
					n.cmd_stb = 1'b1;
					n.state = srpm_pkg::ST_PRE;
				end
				else if (!access_req_i && entry_ok
					&& lpc == `SRPM_LPC_PDOWN)
				begin
					n.cmd = srpm_pkg::CMD_PDENTER;
					n.cmd_stb = 1'b1;
					n.cke = 1'b0;
					wait_load = 1'b1;
					wait_val = {13'h0000, pd_min};
					n.state = srpm_pkg::ST_PD;
				end
			end
			srpm_pkg::ST_REF:
			begin
				if (wait_zero)
				begin
					if (r.emr_dirty && upd_sel && access_req_i)
					begin
						n.cmd = srpm_pkg::CMD_LOADEMR;
						n.cmd_stb = 1'b1;
						n.emr_dirty = 1'b0;
						wait_load = 1'b1;
						wait_val = {13'h0000, t_rfc};
						n.state = srpm_pkg::ST_EMR;
					end
					else
						n.state = srpm_pkg::ST_IDLE;
				end
			end
			srpm_pkg::ST_EMR:
			begin
				if (wait_zero)
					n.state = srpm_pkg::ST_IDLE;
			end
			srpm_pkg::ST_PRE:
			begin
				if (r.emr_dirty && !upd_sel)
				begin
					n.cmd = srpm_pkg::CMD_LOADEMR;
					n.cmd_stb = 1'b1;
					n.emr_dirty = 1'b0;
				end
				n.state = srpm_pkg::ST_SRCMD;
			end
			srpm_pkg::ST_SRCMD:
			begin
				n.cmd_stb = 1'b1;
				wait_load = 1'b1;
				if (access_req_i)
				begin
					n.cmd = srpm_pkg::CMD_AUTOREF;
					wait_val = {13'h0000, t_rfc};
					n.state = srpm_pkg::ST_REF;
				end
				else
				begin
					n.cmd = srpm_pkg::CMD_SELFREF;
					n.cke = 1'b0;
					wait_val = {13'h0000, sr_min};
					n.state = srpm_pkg::ST_SR;
				end
			end
			srpm_pkg::ST_SR:
			begin
				// Device refreshes itself; drop our own request
				n.ref_pend = 1'b0;
				if (wait_zero && (access_req_i || lpc != `SRPM_LPC_SELF))
				begin
					n.cke = 1'b1;
					n.cmd_stb = 1'b1;
					wait_load = 1'b1;
					wait_val = {13'h0000, wake_len};
					n.state = srpm_pkg::ST_WAKE;
				end
			end
			srpm_pkg::ST_PD:
			begin
				if (wait_zero && (access_req_i || r.ref_pend
					|| lpc != `SRPM_LPC_PDOWN))
				begin
					n.cke = 1'b1;
					n.cmd_stb = 1'b1;
					wait_load = 1'b1;
					wait_val = {13'h0000, wake_len};
					n.state = srpm_pkg::ST_WAKE;
				end
			end
			srpm_pkg::ST_WAKE:
			begin
				if (wait_zero)
					n.state = srpm_pkg::ST_IDLE;
			end
			srpm_pkg::ST_DEEP:
			begin
				n.ref_pend = 1'b0;
				if (lpc == `SRPM_LPC_NONE)
					n.state = srpm_pkg::ST_IDLE;
			end
			srpm_pkg::ST_RST:
			begin
				n.ref_pend = 1'b0;
				if (lpc == `SRPM_LPC_NONE && !freeze)
					n.state = srpm_pkg::ST_IDLE;
			end
			default:
				n.state = srpm_pkg::ST_IDLE;
		endcase

		// Sets come last so they win over a clear in the same cycle
		if (ref_expire)
			n.ref_pend = 1'b1;
		if (wr_now && r.a_addr == `SRPM_ADDR_LOWPOWER && init_done_i
			&& hwdata_i[`SRPM_LP_EMR_MSB:`SRPM_LP_EMR_LSB]
			!= r.lp[`SRPM_LP_EMR_MSB:`SRPM_LP_EMR_LSB])
			n.emr_dirty = 1'b1;

		n.busy = (n.state != srpm_pkg::ST_IDLE);
		n.frozen = (n.state == srpm_pkg::ST_DEEP)
			|| (n.state == srpm_pkg::ST_RST);
		n.normal = !n.frozen;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.period <= `SRPM_PERIOD_RST;
			r.lp <= `SRPM_LP_RST;
			r.timing <= `SRPM_TIMING_RST;
			r.hready <= 1'b1;
			r.cke <= 1'b1;
			r.normal <= 1'b1;
		end
		else
			r <= n;
	end

	assign hreadyout_o   = r.hready;
	assign hrdata_o      = r.hrdata;
	assign hresp_o       = 1'b0;
	assign busy_o        = r.busy;
	assign cke_o         = r.cke;
	assign cmd_o         = r.cmd;
	assign cmd_stb_o     = r.cmd_stb;
	assign emr_o         = r.lp[`SRPM_LP_EMR_MSB:`SRPM_LP_EMR_LSB];
	assign normal_mode_o = r.normal;
	assign frozen_o      = r.frozen;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence s_refresh_issued;
		cmd_stb_o && cmd_o == srpm_pkg::CMD_AUTOREF;
	endsequence
	sequence s_sr_entry;
		cmd_stb_o && cmd_o == srpm_pkg::CMD_PREALL ##[1:2]
		cmd_stb_o && (cmd_o == srpm_pkg::CMD_SELFREF
			|| cmd_o == srpm_pkg::CMD_AUTOREF);
	endsequence

	property p_refresh_issue;
		r.state == srpm_pkg::ST_IDLE && r.ref_pend && !burst_active_i
			&& lpc != `SRPM_LPC_DEEP |=> s_refresh_issued;
	endproperty
	a_refresh_issue: assert property (p_refresh_issue)
		else $error("pending refresh not issued");

	property p_reload;
		ref_expire |=> ref_count == $past(ref_val);
	endproperty
	a_reload: assert property (p_reload)
		else $error("refresh timer not reloaded");

	property p_busy;
		r.state == srpm_pkg::ST_REF |-> busy_o;
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy low during refresh");

	property p_no_break;
		burst_active_i && r.state == srpm_pkg::ST_IDLE |=> !cmd_stb_o;
	endproperty
	a_no_break: assert property (p_no_break)
		else $error("command issued during a burst");

	property p_sr_cke;
		r.state == srpm_pkg::ST_SR |-> !cke_o;
	endproperty
	a_sr_cke: assert property (p_sr_cke)
		else $error("clock enable high in self-refresh");

	property p_sr_exit;
		r.state == srpm_pkg::ST_SR && wait_zero && access_req_i
			|=> r.state == srpm_pkg::ST_WAKE && cke_o ##1 busy_o;
	endproperty
	a_sr_exit: assert property (p_sr_exit)
		else $error("self-refresh not left on access");

	property p_timeout;
		r.state == srpm_pkg::ST_IDLE && tmo == `SRPM_TMO_128
			&& r.idle_cnt < `SRPM_IDLE_128
			|=> !(cmd_stb_o && (cmd_o == srpm_pkg::CMD_PREALL
			|| cmd_o == srpm_pkg::CMD_PDENTER));
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("low-power entry before timeout");

	property p_sr_entry;
		cmd_stb_o && cmd_o == srpm_pkg::CMD_PREALL |-> s_sr_entry;
	endproperty
	a_sr_entry: assert property (p_sr_entry)
		else $error("precharge not followed by refresh command");

	property p_sr_hold;
		r.state == srpm_pkg::ST_SR && !wait_zero
			|=> r.state == srpm_pkg::ST_SR;
	endproperty
	a_sr_hold: assert property (p_sr_hold)
		else $error("self-refresh left before minimum");

	property p_frozen;
		r.state == srpm_pkg::ST_DEEP |-> frozen_o && !normal_mode_o;
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("deep power-down not frozen");
endmodule // srpm_top

// ==== testbench/srpm_sdram_model.sv ====
`timescale 1ns/1ns
module srpm_sdram_model (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        cke_i,
	input  wire logic [2:0]  cmd_i,
	input  wire logic        cmd_stb_i,
	output logic      [15:0] refresh_count_o,
	output logic      [15:0] last_stay_o,
	output logic      [7:0]  order_err_o
);
	typedef struct packed {
		logic        low;
		logic [2:0]  last;
		logic [15:0] stay;
		logic [15:0] last_stay;
		logic [15:0] refs;
		logic [7:0]  errs;
	} srpm_mdl_s;

	srpm_mdl_s r_reg;
	srpm_mdl_s r_next;

	////////////////////////////////////////////////////////////////////////
	// Memory in a low-power state takes only the exit NOP, with clock off
	always_comb
	begin
		r_next = r_reg;
		if (r_reg.low)
			r_next.stay = r_reg.stay + 16'h0001;
		if (r_reg.low && (cmd_stb_i ? cmd_i != srpm_pkg::CMD_NOP : cke_i))
			r_next.errs = r_reg.errs + 8'h01;
		if (cmd_stb_i)
		begin
			r_next.last = cmd_i;
			case (cmd_i)
				srpm_pkg::CMD_AUTOREF:
					r_next.refs = r_reg.refs + 16'h0001;
				srpm_pkg::CMD_SELFREF:
				begin
					// Banks must be closed before the memory clocks itself
					if (r_reg.last != srpm_pkg::CMD_PREALL &&
						r_reg.last != srpm_pkg::CMD_LOADEMR)
						r_next.errs = r_reg.errs + 8'h01;
					r_next.low = 1'b1;
					r_next.stay = 16'h0000;
				end
				srpm_pkg::CMD_PDENTER:
				begin
					r_next.low = 1'b1;
					r_next.stay = 16'h0000;
				end
				srpm_pkg::CMD_NOP:
				begin
					if (r_reg.low)
						r_next.last_stay = r_reg.stay;
					r_next.low = 1'b0;
				end
				default:
					r_next.low = r_reg.low;
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign refresh_count_o = r_reg.refs;
	assign last_stay_o = r_reg.last_stay;
	assign order_err_o = r_reg.errs;
endmodule // srpm_sdram_model

// ==== testbench/tb_srpm_top.sv ====
`timescale 1ns/1ns
`include "srpm_defines.svh"
module tb_srpm_top;
	logic        clock_i = 1'b0;
	logic        rst_i;
	logic        hsel_i;
	logic [31:0] haddr_i;
	logic [1:0]  htrans_i;
	logic        hwrite_i;
	logic [31:0] hwdata_i;
	logic        hreadyout_o;
	logic [31:0] hrdata_o;
	logic        hresp_o;
	logic        init_done_i;
	logic        access_req_i;
	logic        burst_active_i;
	logic        busy_o;
	logic        cke_o;
	logic [2:0]  cmd_o;
	logic        cmd_stb_o;
	logic [6:0]  emr_o;
	logic        normal_mode_o;
	logic        frozen_o;
	logic [15:0] refs;
	logic [15:0] stay;
	logic [7:0]  errs;
	logic [15:0] c0;
	logic [31:0] off [2];
	int          fails = 0;
	int          check_count = 0;
	int          n;
	int          thr;

	always #20 clock_i = ~clock_i;

	// Short refresh ceiling keeps the clamp reachable in a short run
	srpm_top #(.REFRESH_MAX_CYC(21'd200)) DUT (
		.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
		.init_done_i(init_done_i), .access_req_i(access_req_i),
		.burst_active_i(burst_active_i), .busy_o(busy_o),
		.cke_o(cke_o), .cmd_o(cmd_o), .cmd_stb_o(cmd_stb_o),
		.emr_o(emr_o), .normal_mode_o(normal_mode_o),
		.frozen_o(frozen_o));

	srpm_sdram_model mem (
		.clock_i(clock_i), .rst_i(rst_i), .cke_i(cke_o), .cmd_i(cmd_o),
		.cmd_stb_i(cmd_stb_o), .refresh_count_o(refs),
		.last_stay_o(stay), .order_err_o(errs));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, e, input string m);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {24'h0, a};
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk(q, e, "register read");
		chk({31'h0, hresp_o}, 32'h0, "bus response");
	endtask

	// Waits for one strobed command; checks clock enable beside it
	task automatic wait_cmd(input logic [2:0] c, input logic ck,
		input int lim, output int k);
		k = 0;
		do
		begin
			@(negedge clock_i);
			k++;
		end
		while (!(cmd_stb_o === 1'b1 && cmd_o === c) && k < lim);
		chk(32'(k < lim), 32'h1, "command missing");
		chk({31'h0, cke_o}, {31'h0, ck}, "clock enable");
		@(posedge clock_i);
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#800000;
		fails++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		conclude();
	end

	initial
	begin
		rst_i = 1'b1;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		init_done_i = 1'b0;
		access_req_i = 1'b0;
		burst_active_i = 1'b0;
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		@(negedge clock_i);
		chk({26'h0, hreadyout_o, cke_o, cmd_stb_o, busy_o, normal_mode_o,
			frozen_o}, 32'h32, "reset outputs");
		@(posedge clock_i);
		rd_chk(`SRPM_ADDR_TIMING, 32'h01010101);
		rd_chk(`SRPM_ADDR_PERIOD, 32'h0);
		rd_chk(`SRPM_ADDR_LOWPOWER, 32'h0);
		rd_chk(`SRPM_ADDR_STATUS, 32'h80);
		wr(8'h40, 32'hFFFFFFFF);
		rd_chk(8'h40, 32'h0);
		$display("test reset done");

		wr(`SRPM_ADDR_TIMING, 32'h0406030C);
		rd_chk(`SRPM_ADDR_TIMING, 32'h0406030C);
		wr(`SRPM_ADDR_PERIOD, 32'h28);
		wait_cmd(srpm_pkg::CMD_AUTOREF, 1'b1, 60, n);
		chk({31'h0, busy_o}, 32'h1, "busy during refresh");
		wait_cmd(srpm_pkg::CMD_AUTOREF, 1'b1, 60, n);
		chk(32'(n >= 38 && n <= 44), 32'h1, "refresh interval");
		burst_active_i <= 1'b1;
		@(negedge clock_i);
		c0 = refs;
		repeat (100) @(posedge clock_i);
		chk({16'h0, refs}, {16'h0, c0}, "refresh broke a burst");
		burst_active_i <= 1'b0;
		wait_cmd(srpm_pkg::CMD_AUTOREF, 1'b1, 6, n);
		// Shared-bus update rides on a refresh with an access waiting
		init_done_i <= 1'b1;
		wr(`SRPM_ADDR_LOWPOWER, 32'h00004A40);
		wait_cmd(srpm_pkg::CMD_AUTOREF, 1'b1, 60, n);
		access_req_i <= 1'b1;
		wait_cmd(srpm_pkg::CMD_LOADEMR, 1'b1, 10, n);
		chk({25'h0, emr_o}, 32'h4A, "shared ext mode bits");
		access_req_i <= 1'b0;
		wr(`SRPM_ADDR_PERIOD, 32'h0);
		$display("test refresh done");

		init_done_i <= 1'b1;
		wr(`SRPM_ADDR_LOWPOWER, 32'h00015501);
		wait_cmd(srpm_pkg::CMD_PREALL, 1'b1, 30, n);
		wait_cmd(srpm_pkg::CMD_LOADEMR, 1'b1, 10, n);
		chk({25'h0, emr_o}, 32'h55, "ext mode bits");
		wait_cmd(srpm_pkg::CMD_SELFREF, 1'b0, 10, n);
		access_req_i <= 1'b1;
		wait_cmd(srpm_pkg::CMD_NOP, 1'b1, 40, n);
		@(negedge clock_i);
		chk(32'(stay + 16'h1 >= 16'd12), 32'h1, "short self stay");
		@(posedge clock_i);
		access_req_i <= 1'b0;
		wait_cmd(srpm_pkg::CMD_PREALL, 1'b1, 6, n);
		access_req_i <= 1'b1;
		wait_cmd(srpm_pkg::CMD_AUTOREF, 1'b1, 4, n);
		access_req_i <= 1'b0;
		wait_cmd(srpm_pkg::CMD_PREALL, 1'b1, 10, n);
		wait_cmd(srpm_pkg::CMD_SELFREF, 1'b0, 10, n);
		for (int i = 1; i <= 2; i++)
		begin
			thr = 64 * i;
			wr(`SRPM_ADDR_LOWPOWER, 32'h00015501 | (i << 4));
			access_req_i <= 1'b1;
			wait_cmd(srpm_pkg::CMD_NOP, 1'b1, 40, n);
			repeat (10) @(posedge clock_i);
			access_req_i <= 1'b0;
			wait_cmd(srpm_pkg::CMD_PREALL, 1'b1, 300, n);
			chk(32'(n >= thr - 1 && n <= thr + 6), 32'h1, "idle delay");
			wait_cmd(srpm_pkg::CMD_SELFREF, 1'b0, 10, n);
		end
		$display("test self refresh done");

		wr(`SRPM_ADDR_LOWPOWER, 32'h00025502);
		wait_cmd(srpm_pkg::CMD_NOP, 1'b1, 40, n);
		wait_cmd(srpm_pkg::CMD_PDENTER, 1'b0, 40, n);
		access_req_i <= 1'b1;
		wait_cmd(srpm_pkg::CMD_NOP, 1'b1, 40, n);
		@(negedge clock_i);
		chk(32'(stay + 16'h1 >= 16'd6), 32'h1, "short down stay");
		@(posedge clock_i);
		access_req_i <= 1'b0;
		wait_cmd(srpm_pkg::CMD_PDENTER, 1'b0, 10, n);
		wr(`SRPM_ADDR_PERIOD, 32'h12C);
		wait_cmd(srpm_pkg::CMD_AUTOREF, 1'b1, 250, n);
		wait_cmd(srpm_pkg::CMD_AUTOREF, 1'b1, 250, n);
		chk(32'(n >= 190 && n <= 206), 32'h1, "refresh ceiling");
		wr(`SRPM_ADDR_PERIOD, 32'h0);
		chk({24'h0, errs}, 32'h0, "memory saw bad sequence");
		$display("test power-down done");

		// Deep power-down frees on 00 alone; reset also needs freeze clear
		off[0] = 32'h00025500;
		off[1] = 32'h00035504;
		for (int i = 0; i < 2; i++)
		begin
			wr(`SRPM_ADDR_LOWPOWER,
				i ? 32'h00035507 : 32'h00025503);
			wait_cmd(i ? srpm_pkg::CMD_DDRRESET : srpm_pkg::CMD_DEEPPD,
				1'b0, 60, n);
			@(negedge clock_i);
			chk({29'h0, normal_mode_o, frozen_o, busy_o}, 32'h3,
				"frozen");
			@(posedge clock_i);
			wr(`SRPM_ADDR_LOWPOWER, off[i]);
			repeat (4) @(posedge clock_i);
			chk({31'h0, normal_mode_o}, 32'(i == 0), "release");
			wr(`SRPM_ADDR_LOWPOWER, 32'h00025500);
			repeat (4) @(posedge clock_i);
			chk({31'h0, normal_mode_o}, 32'h1, "normal again");
		end
		$display("test freeze done");
		conclude();
	end
endmodule // tb_srpm_top
